// *** logic/oas_pkg.sv ***
// constants, register map and reset values of the output arbiter block
package oas_pkg;

	// ------------------------------------------------------------
	// bus and register map
	// ------------------------------------------------------------
	localparam int        AW           = 8;
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_ADDR     = 8'h04;
	localparam logic [7:0] REG_BAUD     = 8'h08;
	localparam logic [7:0] REG_PAR      = 8'h0C;
	localparam logic [7:0] REG_WD_TIME  = 8'h10;
	localparam logic [7:0] REG_WD_CFG   = 8'h14;
	localparam logic [7:0] REG_MANUAL   = 8'h18;
	localparam logic [7:0] REG_ALM_CFG  = 8'h1C;
	localparam logic [7:0] REG_CAL_CMD  = 8'h20;
	localparam logic [7:0] REG_IRQ_STAT = 8'h24;
	localparam logic [7:0] REG_IRQ_MASK = 8'h28;
	localparam logic [7:0] REG_STATUS   = 8'h2C;
	localparam logic [7:0] REG_RNG_LO   = 8'h30;
	localparam logic [7:0] REG_RNG_HI   = 8'h34;
	localparam logic [7:0] CH_BASE      = 8'h40;
	localparam int        CH_SHIFT     = 5;
	localparam int        MAX_CH       = 4;

	// word index inside a channel window
	localparam logic [2:0] SUB_HI_LIM = 3'h0;
	localparam logic [2:0] SUB_LO_LIM = 3'h1;
	localparam logic [2:0] SUB_DBAND  = 3'h2;
	localparam logic [2:0] SUB_CAL_LO = 3'h3;
	localparam logic [2:0] SUB_CAL_HI = 3'h4;
	localparam logic [2:0] SUB_VALUE  = 3'h5;
	localparam logic [2:0] SUB_STAT   = 3'h6;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_RES_BIT = 0;
	localparam int WD_EN_POS    = 0;
	localparam int WD_VAL_POS   = 8;
	localparam int HI_EN_POS    = 0;
	localparam int LO_EN_POS    = 4;
	localparam int FSAFE_POS    = 8;
	localparam int CAL_LO_BIT   = 0;
	localparam int CAL_HI_BIT   = 1;
	localparam int CAL_CH_POS   = 4;
	localparam int ST_FALLBACK  = 0;
	localparam int ST_WD_TMO    = 1;
	localparam int ST_OUT_POS   = 8;
	localparam int IRQ_WD       = 0;
	localparam int IRQ_ALM      = 1;
	localparam int IRQ_RNG      = 2;
	localparam int IRQ_W        = 3;

	// ------------------------------------------------------------
	// communication settings
	// ------------------------------------------------------------
	localparam logic [7:0]  FB_ADDR  = 8'hF7;
	localparam logic [19:0] FB_BAUD  = 20'h02580;
	localparam logic [1:0]  PAR_NONE = 2'h0;
	localparam logic [7:0]  RST_ADDR = 8'h01;
	localparam logic [19:0] RST_BAUD = 20'h02580;
	localparam logic [1:0]  RST_PAR  = 2'h0;

	// ------------------------------------------------------------
	// scaling and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] SPAN_FULL   = 16'h4E20;
	localparam logic [15:0] RST_RNG_LO  = 16'hFF38;
	localparam logic [15:0] RST_RNG_HI  = 16'h0352;
	localparam logic [15:0] RST_CAL_LO  = 16'h0000;
	localparam logic [15:0] RST_CAL_HI  = 16'hFFFF;
	localparam logic [15:0] RST_DBAND   = 16'h0000;
	localparam logic [15:0] RST_WD_TIME = 16'h0000;

	typedef enum logic [1:0] {
		OAS_UNDER  = 2'b00,
		OAS_NORMAL = 2'b01,
		OAS_LIMIT  = 2'b10,
		OAS_OVER   = 2'b11
	} oas_stat_t;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam longint CLK_HZ    = 200000000;
	localparam longint WD_UNIT_S = 1;
	localparam longint WD_TICKS  = WD_UNIT_S * CLK_HZ;

endpackage

// *** logic/oas_scale.sv ***
// one channel: two-point calibrated scaling and input classification
`timescale 1ns/1ps
module oas_scale
	import oas_pkg::*;
(
	input  wire logic [15:0] raw,
	input  wire logic [15:0] cal_lo,
	input  wire logic [15:0] cal_hi,
	input  wire logic [15:0] ep_lo,
	input  wire logic [15:0] ep_hi,
	input  wire logic [15:0] hi_lim,
	input  wire logic [15:0] lo_lim,
	output logic      [15:0] value,
	output oas_stat_t        stat
);
	logic signed [17:0] diff;
	logic signed [17:0] den;
	logic signed [17:0] span;
	logic signed [35:0] num;
	logic signed [35:0] quo;
	logic signed [35:0] sum;
	logic signed [15:0] v;

	always_comb
	begin
		diff = $signed({2'b00, raw}) - $signed({2'b00, cal_lo});
		den  = $signed({2'b00, cal_hi}) - $signed({2'b00, cal_lo});
		span = 18'($signed(ep_hi)) - 18'($signed(ep_lo));
		num  = 36'(diff) * 36'(span);
		// endpoints map onto the captured calibration points
		quo  = (den > 18'sd0) ? num / 36'(den) : 36'sd0;
		sum  = quo + 36'($signed(ep_lo));
		if (sum > 36'sd32767)
			v = 16'sh7FFF;
		else if (sum < -36'sd32768)
			v = 16'sh8000;
		else
			v = sum[15:0];
		value = v;
		if (v < $signed(ep_lo))
			stat = OAS_UNDER;
		else if (v > $signed(ep_hi))
			stat = OAS_OVER;
		else if (v >= $signed(hi_lim) || v <= $signed(lo_lim))
			stat = OAS_LIMIT;
		else
			stat = OAS_NORMAL;
	end
endmodule

// *** logic/oas_ctrl.sv ***
// output arbiter, watchdog, alarm, calibration and wishbone register file
`timescale 1ns/1ps
module oas_ctrl
	import oas_pkg::*;
#(
	parameter int     NCH           = 4,
	parameter longint TICKS_PER_SEC = WD_TICKS
)
(
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [AW-1:0]     wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              scan_stb,
	input  wire logic [NCH*16-1:0] raw_in,
	input  wire logic              net_io,
	input  wire logic              host_rst,
	input  wire logic              dft_press,
	output logic      [NCH-1:0]    relay_on,
	output logic      [7:0]        comm_addr,
	output logic      [19:0]       comm_baud,
	output logic      [1:0]        comm_parity,
	output logic                   fallback,
	output logic                   wd_timeout,
	output logic                   irq
);
	// ------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------
	if (NCH < 1 || NCH > MAX_CH)
		$error("oas_ctrl: NCH must be 1 to 4");
	if (TICKS_PER_SEC < 2 || TICKS_PER_SEC > 64'hFFFFFFFF)
		$error("oas_ctrl: TICKS_PER_SEC out of range");

	localparam logic [31:0] TICK_LAST = 32'(TICKS_PER_SEC - 1);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic                   ack;
		logic [31:0]            rdat;
		logic                   res_mode;
		logic [7:0]             st_addr;
		logic [19:0]            st_baud;
		logic [1:0]             st_par;
		logic                   fallback;
		logic [7:0]             c_addr;
		logic [19:0]            c_baud;
		logic [1:0]             c_par;
		logic [15:0]            wd_time;
		logic [NCH-1:0]         wd_en;
		logic [NCH-1:0]         wd_val;
		logic [NCH-1:0]         manual;
		logic [NCH-1:0]         hi_en;
		logic [NCH-1:0]         lo_en;
		logic [NCH-1:0]         fsafe;
		logic [15:0]            rng_lo;
		logic [15:0]            rng_hi;
		logic [NCH-1:0][15:0]   hi_lim;
		logic [NCH-1:0][15:0]   lo_lim;
		logic [NCH-1:0][15:0]   dband;
		logic [NCH-1:0][15:0]   cal_lo;
		logic [NCH-1:0][15:0]   cal_hi;
		logic [NCH-1:0][15:0]   value;
		logic [NCH-1:0][1:0]    stat;
		logic [NCH-1:0]         alarm;
		logic [NCH-1:0]         out;
		logic [31:0]            pre;
		logic [15:0]            secs;
		logic                   wd_tmo;
		logic [IRQ_W-1:0]       irq_stat;
		logic [IRQ_W-1:0]       irq_mask;
		logic                   irq;
	} oas_state_t;

	localparam oas_state_t ST_RST = '{
		st_addr: RST_ADDR, st_baud: RST_BAUD, st_par: RST_PAR,
		c_addr: RST_ADDR, c_baud: RST_BAUD, c_par: RST_PAR,
		wd_time: RST_WD_TIME, rng_lo: RST_RNG_LO, rng_hi: RST_RNG_HI,
		hi_lim: {NCH{RST_RNG_HI}}, lo_lim: {NCH{RST_RNG_LO}},
		dband: {NCH{RST_DBAND}}, cal_lo: {NCH{RST_CAL_LO}},
		cal_hi: {NCH{RST_CAL_HI}}, stat: {NCH{OAS_NORMAL}},
		default: '0
	};

	oas_state_t s_r;
	oas_state_t s_nxt;

	// ------------------------------------------------------------
	// byte-lane merge for register writes
	// ------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		return r;
	endfunction

	// ------------------------------------------------------------
	// per-channel scaling
	// ------------------------------------------------------------
	logic [NCH-1:0][15:0] sc_val;
	logic [NCH-1:0][1:0]  sc_stat;
	logic [15:0]          ep_lo;
	logic [15:0]          ep_hi;

	// resistance reads in span units, sensors in degrees Celsius
	assign ep_lo = s_r.res_mode ? 16'h0000 : s_r.rng_lo;
	assign ep_hi = s_r.res_mode ? SPAN_FULL : s_r.rng_hi;

	for (genvar g = 0; g < NCH; g++)
	begin : g_ch
		oas_stat_t st;
		oas_scale u_scale (
			.raw    (raw_in[g*16 +: 16]),
			.cal_lo (s_r.cal_lo[g]),
			.cal_hi (s_r.cal_hi[g]),
			.ep_lo  (ep_lo),
			.ep_hi  (ep_hi),
			.hi_lim (s_r.hi_lim[g]),
			.lo_lim (s_r.lo_lim[g]),
			.value  (sc_val[g]),
			.stat   (st)
		);
		assign sc_stat[g] = st;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic              req;
		logic [31:0]       cur;
		logic [31:0]       wv;
		logic [IRQ_W-1:0]  ev;
		logic [2:0]        sub;
		int                ch;
		logic signed [16:0] v;
		logic signed [16:0] hi_clr;
		logic signed [16:0] lo_clr;
		logic              trip;
		req    = wb_cyc_i & wb_stb_i & ~s_r.ack;
		cur    = 32'h0;
		wv     = 32'h0;
		ev     = '0;
		sub    = wb_adr_i[4:2];
		ch     = int'(wb_adr_i[AW-1:CH_SHIFT]) - int'(CH_BASE >> CH_SHIFT);
		v      = '0;
		hi_clr = '0;
		lo_clr = '0;
		trip   = 1'b0;
		s_nxt  = s_r;
		s_nxt.ack = req;

		// register read-back, configuration included
		case (wb_adr_i)
			REG_CTRL:     cur = 32'(s_r.res_mode);
			REG_ADDR:     cur = 32'(s_r.st_addr);
			REG_BAUD:     cur = 32'(s_r.st_baud);
			REG_PAR:      cur = 32'(s_r.st_par);
			REG_WD_TIME:  cur = 32'(s_r.wd_time);
			REG_WD_CFG:   cur = (32'(s_r.wd_en) << WD_EN_POS) | (32'(s_r.wd_val) << WD_VAL_POS);
			REG_MANUAL:   cur = 32'(s_r.manual);
			REG_ALM_CFG:  cur = (32'(s_r.hi_en) << HI_EN_POS) | (32'(s_r.lo_en) << LO_EN_POS)
				| (32'(s_r.fsafe) << FSAFE_POS);
			REG_IRQ_STAT: cur = 32'(s_r.irq_stat);
			REG_IRQ_MASK: cur = 32'(s_r.irq_mask);
			REG_STATUS:   cur = (32'(s_r.fallback) << ST_FALLBACK) | (32'(s_r.wd_tmo) << ST_WD_TMO)
				| (32'(s_r.out) << ST_OUT_POS);
			REG_RNG_LO:   cur = 32'(s_r.rng_lo);
			REG_RNG_HI:   cur = 32'(s_r.rng_hi);
			default:
				if (ch >= 0 && ch < NCH)
					case (sub)
						SUB_HI_LIM: cur = 32'(s_r.hi_lim[ch]);
						SUB_LO_LIM: cur = 32'(s_r.lo_lim[ch]);
						SUB_DBAND:  cur = 32'(s_r.dband[ch]);
						SUB_CAL_LO: cur = 32'(s_r.cal_lo[ch]);
						SUB_CAL_HI: cur = 32'(s_r.cal_hi[ch]);
						SUB_VALUE:  cur = 32'(s_r.value[ch]);
						SUB_STAT:   cur = 32'(s_r.stat[ch]);
						default:    cur = 32'h0;
					endcase
		endcase
		if (req)
			s_nxt.rdat = cur;
		wv = merge(cur, wb_dat_i, wb_sel_i);

		// ------------------------------------------------------------
		// register writes
		// ------------------------------------------------------------
		if (req && wb_we_i)
		begin
			case (wb_adr_i)
				REG_CTRL:     s_nxt.res_mode = wv[CTRL_RES_BIT];
				REG_ADDR:     s_nxt.st_addr = wv[7:0];
				REG_BAUD:     s_nxt.st_baud = wv[19:0];
				REG_PAR:      s_nxt.st_par = wv[1:0];
				REG_WD_TIME:  s_nxt.wd_time = wv[15:0];
				REG_WD_CFG:
				begin
					s_nxt.wd_en  = wv[WD_EN_POS +: NCH];
					s_nxt.wd_val = wv[WD_VAL_POS +: NCH];
				end
				REG_MANUAL:   s_nxt.manual = wv[NCH-1:0];
				REG_ALM_CFG:
				begin
					s_nxt.hi_en = wv[HI_EN_POS +: NCH];
					s_nxt.lo_en = wv[LO_EN_POS +: NCH];
					s_nxt.fsafe = wv[FSAFE_POS +: NCH];
				end
				REG_CAL_CMD:
					// capture the applied input as the new calibration point
					if (int'(wb_dat_i[CAL_CH_POS +: 2]) < NCH)
					begin
						if (wb_dat_i[CAL_LO_BIT])
							s_nxt.cal_lo[wb_dat_i[CAL_CH_POS +: 2]] =
								raw_in[16*wb_dat_i[CAL_CH_POS +: 2] +: 16];
						if (wb_dat_i[CAL_HI_BIT])
							s_nxt.cal_hi[wb_dat_i[CAL_CH_POS +: 2]] =
								raw_in[16*wb_dat_i[CAL_CH_POS +: 2] +: 16];
					end
				REG_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~wv[IRQ_W-1:0];
				REG_IRQ_MASK: s_nxt.irq_mask = wv[IRQ_W-1:0];
				REG_RNG_LO:   s_nxt.rng_lo = wv[15:0];
				REG_RNG_HI:   s_nxt.rng_hi = wv[15:0];
				default:
					if (ch >= 0 && ch < NCH)
						case (sub)
							SUB_HI_LIM: s_nxt.hi_lim[ch] = wv[15:0];
							SUB_LO_LIM: s_nxt.lo_lim[ch] = wv[15:0];
							SUB_DBAND:  s_nxt.dband[ch] = wv[15:0];
							SUB_CAL_LO: s_nxt.cal_lo[ch] = wv[15:0];
							SUB_CAL_HI: s_nxt.cal_hi[ch] = wv[15:0];
							default:    ;
						endcase
			endcase
		end

		// ------------------------------------------------------------
		// input scan: value, status, alarm with deadband
		// ------------------------------------------------------------
		if (scan_stb)
			for (int i = 0; i < NCH; i++)
			begin
				s_nxt.value[i] = sc_val[i];
				s_nxt.stat[i]  = sc_stat[i];
				v      = 17'($signed(sc_val[i]));
				hi_clr = 17'($signed(s_r.hi_lim[i])) - 17'($signed(s_r.dband[i]));
				lo_clr = 17'($signed(s_r.lo_lim[i])) + 17'($signed(s_r.dband[i]));
				trip   = (s_r.hi_en[i] && v >= 17'($signed(s_r.hi_lim[i])))
					|| (s_r.lo_en[i] && v <= 17'($signed(s_r.lo_lim[i])));
				if (trip)
					s_nxt.alarm[i] = 1'b1;
				else if ((!s_r.hi_en[i] || v < hi_clr) && (!s_r.lo_en[i] || v > lo_clr))
					s_nxt.alarm[i] = 1'b0;
				if (trip && !s_r.alarm[i])
					ev[IRQ_ALM] = 1'b1;
				if (sc_stat[i] == OAS_UNDER || sc_stat[i] == OAS_OVER)
					ev[IRQ_RNG] = 1'b1;
			end

		// ------------------------------------------------------------
		// watchdog
		// ------------------------------------------------------------
		if (net_io)
		begin
			// renewed traffic restarts the count and hands control back
			s_nxt.pre    = 32'h0;
			s_nxt.secs   = 16'h0;
			s_nxt.wd_tmo = 1'b0;
		end
		else if (s_r.wd_time != 16'h0 && !s_r.wd_tmo)
		begin
			if (s_r.pre == TICK_LAST)
			begin
				s_nxt.pre  = 32'h0;
				s_nxt.secs = s_r.secs + 16'h1;
				if (s_r.secs + 16'h1 == s_r.wd_time)
				begin
					s_nxt.wd_tmo = 1'b1;
					ev[IRQ_WD]   = 1'b1;
				end
			end
			else
				s_nxt.pre = s_r.pre + 32'h1;
		end

		if (dft_press)
			s_nxt.fallback = 1'b1;

		// ------------------------------------------------------------
		// host reset: same volatile effect as power-on
		// ------------------------------------------------------------
		if (host_rst)
		begin
			s_nxt.fallback = 1'b0;
			s_nxt.manual   = ST_RST.manual;
			s_nxt.value    = ST_RST.value;
			s_nxt.stat     = ST_RST.stat;
			s_nxt.alarm    = ST_RST.alarm;
			s_nxt.pre      = ST_RST.pre;
			s_nxt.secs     = ST_RST.secs;
			s_nxt.wd_tmo   = ST_RST.wd_tmo;
			s_nxt.irq_stat = ST_RST.irq_stat;
			s_nxt.irq_mask = ST_RST.irq_mask;
			ev             = '0;
		end

		// set wins over a same-cycle clear
		s_nxt.irq_stat = s_nxt.irq_stat | ev;
		s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);

		// ------------------------------------------------------------
		// output ownership
		// ------------------------------------------------------------
		for (int i = 0; i < NCH; i++)
			if (s_nxt.wd_tmo && s_nxt.wd_en[i])
				s_nxt.out[i] = s_nxt.wd_val[i];
			else if (s_nxt.hi_en[i] || s_nxt.lo_en[i])
				s_nxt.out[i] = s_nxt.alarm[i] ^ s_nxt.fsafe[i];
			else
				s_nxt.out[i] = s_nxt.manual[i];

		// fallback settings or stored ones
		s_nxt.c_addr = s_nxt.fallback ? FB_ADDR : s_nxt.st_addr;
		s_nxt.c_baud = s_nxt.fallback ? FB_BAUD : s_nxt.st_baud;
		s_nxt.c_par  = s_nxt.fallback ? PAR_NONE : s_nxt.st_par;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			s_r <= ST_RST;
		else if (ce)
			s_r <= s_nxt;
	end

	assign wb_dat_o    = s_r.rdat;
	assign wb_ack_o    = s_r.ack;
	assign relay_on    = s_r.out;
	assign comm_addr   = s_r.c_addr;
	assign comm_baud   = s_r.c_baud;
	assign comm_parity = s_r.c_par;
	assign fallback    = s_r.fallback;
	assign wd_timeout  = s_r.wd_tmo;
	assign irq         = s_r.irq;
endmodule

// *** sim/oas_ctrl_props.sv ***
// concurrent checks on the output arbiter ports
`timescale 1ns/1ps
module oas_ctrl_props
	import oas_pkg::*;
#(
	parameter int     NCH           = 4,
	parameter longint TICKS_PER_SEC = WD_TICKS
)
(
	input wire logic           clock,
	input wire logic           sys_rst,
	input wire logic           ce,
	input wire logic           wb_cyc_i,
	input wire logic           wb_stb_i,
	input wire logic           wb_ack_o,
	input wire logic           net_io,
	input wire logic           host_rst,
	input wire logic           dft_press,
	input wire logic [NCH-1:0] relay_on,
	input wire logic [7:0]     comm_addr,
	input wire logic [19:0]    comm_baud,
	input wire logic [1:0]     comm_parity,
	input wire logic           fallback,
	input wire logic           wd_timeout
);
	logic [31:0] idle_r;
	logic [31:0] idle_nxt;

	// cycles since the last watchdog restart
	always_comb
	begin
		idle_nxt = idle_r;
		if (ce && (net_io || host_rst))
			idle_nxt = 32'h00000000;
		else if (ce && idle_r != 32'hFFFFFFFF)
			idle_nxt = idle_r + 32'h00000001;
	end

	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
			idle_r <= 32'h00000000;
		else
			idle_r <= idle_nxt;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_ack_one;
		wb_cyc_i && wb_stb_i && ce && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("bus request not acked");
	property p_ack_pulse;
		wb_ack_o && ce |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_cause;
		wb_ack_o && $past(ce) |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_fb_params;
		fallback |-> comm_addr == FB_ADDR && comm_baud == FB_BAUD && comm_parity == PAR_NONE;
	endproperty
	a_fb_params: assert property (p_fb_params) else $error("fallback settings wrong");
	property p_rst_leave;
		host_rst && ce && !dft_press |=> !fallback;
	endproperty
	a_rst_leave: assert property (p_rst_leave) else $error("fallback kept after reset");
	property p_dft;
		dft_press && ce && !host_rst |=> fallback;
	endproperty
	a_dft: assert property (p_dft) else $error("fallback not entered");
	property p_wd_clear;
		net_io && ce |=> !wd_timeout;
	endproperty
	a_wd_clear: assert property (p_wd_clear) else $error("timeout kept after activity");
	property p_wd_rise;
		$rose(wd_timeout) |-> idle_r >= TICKS_PER_SEC - 1;
	endproperty
	a_wd_rise: assert property (p_wd_rise) else $error("timeout before one second");
	property p_wd_hold;
		wd_timeout && !(ce && (net_io || host_rst)) |=> wd_timeout;
	endproperty
	a_wd_hold: assert property (p_wd_hold) else $error("timeout dropped by itself");
	property p_reset_out;
		$past(sys_rst) |-> !fallback && !wd_timeout && relay_on == '0 && comm_addr == RST_ADDR;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
endmodule

bind oas_ctrl oas_ctrl_props #(.NCH(NCH), .TICKS_PER_SEC(TICKS_PER_SEC)) i_oas_ctrl_props (
	.clock(clock), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .net_io(net_io), .host_rst(host_rst), .dft_press(dft_press),
	.relay_on(relay_on), .comm_addr(comm_addr), .comm_baud(comm_baud),
	.comm_parity(comm_parity), .fallback(fallback), .wd_timeout(wd_timeout));

// *** sim/oas_host_model.sv ***
// network host model: polls the module at a fixed spacing
`timescale 1ns/1ps
module oas_host_model #(
	parameter int POLL_GAP = 4
)
(
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic poll_en,
	output logic      net_io
);
	logic [7:0] gap_r;

	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
		begin
			net_io <= 1'b0;
			gap_r  <= 8'h00;
		end
		else if (poll_en && gap_r == 8'h00)
		begin
			net_io <= 1'b1;
			gap_r  <= 8'(POLL_GAP - 1);
		end
		else
		begin
			net_io <= 1'b0;
			gap_r  <= poll_en ? gap_r - 8'h01 : 8'h00;
		end
endmodule

// *** sim/oas_ctrl_tb.sv ***
// self-checking bench of the output arbiter block
`timescale 1ns/1ps
module oas_ctrl_tb;
	import oas_pkg::*;
	logic clock = 1'b0, sys_rst = 1'b1, ce = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0, scan_stb = 1'b0, host_rst = 1'b0, dft_press = 1'b0, poll_en = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, q;
	logic [63:0] raw_in = 64'h0;
	logic [3:0]  relay_on;
	logic [7:0]  comm_addr;
	logic [19:0] comm_baud;
	logic [1:0]  comm_parity;
	logic        wb_ack_o, net_io, fallback, wd_timeout, irq;
	int          failures = 0, checks = 0;
	logic [15:0] raws [4] = '{16'h2000, 16'h2C00, 16'h4000, 16'h0800};
	logic [15:0] vals [4] = '{16'h2710, 16'h445C, 16'h7530, 16'hEC78};

	oas_ctrl #(.NCH(4), .TICKS_PER_SEC(10)) i_oas_ctrl (.clock(clock), .sys_rst(sys_rst),
		.ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .scan_stb(scan_stb), .raw_in(raw_in), .net_io(net_io),
		.host_rst(host_rst), .dft_press(dft_press), .relay_on(relay_on),
		.comm_addr(comm_addr), .comm_baud(comm_baud), .comm_parity(comm_parity),
		.fallback(fallback), .wd_timeout(wd_timeout), .irq(irq));
	oas_host_model #(.POLL_GAP(4)) i_oas_host_model (.clock(clock), .sys_rst(sys_rst),
		.poll_en(poll_en), .net_io(net_io));

	always #2.5 clock = ~clock;

	// ------------------------------------------------------------
	// bus, compare and input scan tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hF, d};
		@(posedge clock);
		while (wb_ack_o !== 1'b1 && n < 20)
		begin
			@(posedge clock);
			n++;
		end
		if (n >= 20)
		begin
			failures++;
			$display("ERROR %0t: no bus ack", $time);
		end
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h00000000);
		chk({16'h0000, q[15:0]}, exp);
	endtask

	task automatic scan(input logic [15:0] r);
		@(posedge clock);
		raw_in <= {48'h0, r};
		scan_stb <= 1'b1;
		@(posedge clock);
		scan_stb <= 1'b0;
		#1;
	endtask

	// ------------------------------------------------------------
	// scenarios and verdict
	// ------------------------------------------------------------
	task automatic t_comm;
		chk({12'h0, comm_baud}, {12'h0, RST_BAUD});
		wr(REG_ADDR, 32'h00000022);
		@(posedge clock);
		dft_press <= 1'b1;
		@(posedge clock);
		dft_press <= 1'b0;
		#1;
		chk({fallback, comm_parity, comm_addr}, {1'b1, PAR_NONE, FB_ADDR});
		@(posedge clock);
		host_rst <= 1'b1;
		@(posedge clock);
		host_rst <= 1'b0;
		#1;
		chk({fallback, comm_addr}, 9'h022);
		rd(REG_ADDR, 32'h00000022);
		rd(8'hFC, 32'h00000000);
		// frozen clock enable swallows the fallback press
		@(posedge clock);
		{ce, dft_press} <= 2'b01;
		@(posedge clock);
		{ce, dft_press} <= 2'b10;
		#1;
		chk(fallback, 1'b0);
		$display("test comm done");
	endtask

	task automatic t_scale;
		wr(REG_CTRL, 32'h0);
		raw_in <= 64'h1000;
		wr(REG_CAL_CMD, 32'h1);
		raw_in <= 64'h3000;
		wr(REG_CAL_CMD, 32'h2);
		rd(8'h4C, 32'h1000);
		rd(8'h50, 32'h3000);
		scan(16'h2000);
		rd(8'h54, 32'h0145);
		wr(REG_CTRL, 32'h1);
		wr(8'h40, 32'h3A98);
		wr(8'h44, 32'hE0C0);
		for (int i = 0; i < 4; i++)
		begin
			scan(raws[i]);
			rd(8'h54, {16'h0, vals[i]});
			rd(8'h58, (i + 1) % 4);
		end
		wr(REG_ALM_CFG, 32'h001);
		wr(REG_MANUAL, 32'h1);
		scan(16'h2000);
		chk(relay_on, 4'h0);
		scan(16'h2C00);
		chk(relay_on, 4'h1);
		wr(REG_ALM_CFG, 32'h101);
		#1;
		chk(relay_on, 4'h0);
		wr(REG_ALM_CFG, 32'h000);
		#1;
		chk(relay_on, 4'h1);
		$display("test scale done");
	endtask

	task automatic t_wdog;
		int n;
		n = 0;
		poll_en <= 1'b1;
		wr(REG_MANUAL, 32'h0);
		wr(REG_IRQ_MASK, 32'h0);
		wr(REG_WD_CFG, 32'h101);
		wr(REG_WD_TIME, 32'h1);
		repeat (60) @(posedge clock);
		chk(wd_timeout, 1'b0);
		poll_en <= 1'b0;
		while (wd_timeout !== 1'b1 && n < 40)
		begin
			@(posedge clock);
			n++;
		end
		#1;
		chk({wd_timeout, irq, relay_on}, 6'h21);
		wr(REG_IRQ_MASK, 32'h1);
		#1;
		chk(irq, 1'b1);
		wr(REG_WD_TIME, 32'h0);
		wr(REG_MANUAL, 32'h2);
		poll_en <= 1'b1;
		repeat (3) @(posedge clock);
		poll_en <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk({wd_timeout, relay_on}, 5'h02);
		wr(REG_IRQ_STAT, 32'h1);
		#1;
		chk(irq, 1'b0);
		$display("test watchdog done");
	endtask

	task automatic print_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		#1;
		t_comm();
		t_scale();
		t_wdog();
		print_verdict();
	end

	initial
	begin
		#20000;
		failures++;
		$display("ERROR %0t: run timed out", $time);
		print_verdict();
	end
endmodule
